// ### src/aro_regs.sv
// converter result and primary offset coefficient registers, wishbone slave
// assumes the converter datapath gives one-cycle valid pulses and a factory offset level

`timescale 1ns/100ps

module aro_regs #(
    parameter int unsigned IDLE_SETTLE_CYCLES = 5750
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aro_pkg::ARO_AW-1:0] wb_adr_i,
    input wire logic [aro_pkg::ARO_SW-1:0] wb_sel_i,
    input wire logic [aro_pkg::ARO_DW-1:0] wb_dat_i,
    output logic [aro_pkg::ARO_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pri_conv_valid,
    input wire logic [aro_pkg::ARO_RESULT_W-1:0] pri_conv_data,
    input wire logic aux_conv_valid,
    input wire logic [aro_pkg::ARO_RESULT_W-1:0] aux_conv_data,
    input wire logic cal_done,
    input wire logic [aro_pkg::ARO_COEF_W-1:0] cal_offset,
    input wire logic [aro_pkg::ARO_COEF_W-1:0] factory_offset,
    output logic [aro_pkg::ARO_MODE_W-1:0] converter_mode,
    output logic pri_enable,
    output logic [aro_pkg::ARO_COEF_W-1:0] primary_offset_coefficient,
    output logic pri_ready,
    output logic aux_ready
);
    import aro_pkg::*;

    initial begin
        if (IDLE_SETTLE_CYCLES < 1) begin
            $error("idle settle count must be at least one cycle");
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic addr_hit(input logic [ARO_AW-1:0] adr, input logic [31:0] ofs);
        addr_hit = (adr == ofs);
    endfunction : addr_hit

    function automatic logic mode_legal(input logic [ARO_MODE_W-1:0] m);
        case (m)
            ARO_MODE_OFF, ARO_MODE_IDLE, ARO_MODE_SINGLE, ARO_MODE_CONT, ARO_MODE_OFS_CAL: begin
                mode_legal = 1'b1;
            end
            default: begin
                mode_legal = 1'b0;
            end
        endcase
    endfunction : mode_legal

    // ****************************************
    // state
    // ****************************************
    logic ack_r;
    logic ack_nxt;
    logic [ARO_DW-1:0] dat_r;
    logic [ARO_DW-1:0] dat_nxt;
    logic [ARO_RESULT_W-1:0] pri_res_r;
    logic [ARO_RESULT_W-1:0] pri_res_nxt;
    logic [ARO_RESULT_W-1:0] aux_res_r;
    logic [ARO_RESULT_W-1:0] aux_res_nxt;
    logic [1:0] rdy_r;
    logic [1:0] rdy_nxt;
    logic [ARO_COEF_W-1:0] coef_r;
    logic [ARO_COEF_W-1:0] coef_nxt;
    logic factory_load_r;
    logic factory_load_nxt;
    aro_mode_t mode_r;
    aro_mode_t mode_nxt;
    logic pri_en_r;
    logic pri_en_nxt;
    logic idle_ok;
    logic coef_wr_ok;
    logic req;
    logic rd;
    logic wr;

    // ****************************************
    // idle settling
    // ****************************************
    aro_idle_timer #(
        .SETTLE_CYCLES(IDLE_SETTLE_CYCLES)
    ) u_idle_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .idle_active(pri_en_r && (mode_r == ARO_MODE_IDLE)),
        .idle_ok(idle_ok)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_r;
        rd = req && !wb_we_i;
        wr = req && wb_we_i;
        // timer output lags the mode by a cycle, so gate on the live mode too
        coef_wr_ok = idle_ok && pri_en_r && (mode_r == ARO_MODE_IDLE);
        ack_nxt = req;
        dat_nxt = ARO_DATA_ZERO;
        pri_res_nxt = pri_res_r;
        aux_res_nxt = aux_res_r;
        rdy_nxt = rdy_r;
        coef_nxt = coef_r;
        factory_load_nxt = 1'b0;
        mode_nxt = mode_r;
        pri_en_nxt = pri_en_r;

        // read mux; unmapped reads answer zero
        if (rd && addr_hit(wb_adr_i, ARO_PRI_RESULT_OFS)) begin
            dat_nxt = {8'h00, pri_res_r};
            rdy_nxt = 2'b00;
        end else if (rd && addr_hit(wb_adr_i, ARO_AUX_RESULT_OFS)) begin
            dat_nxt = {8'h00, aux_res_r};
        end else if (rd && addr_hit(wb_adr_i, ARO_PRI_OFFSET_OFS)) begin
            dat_nxt = {16'h0000, coef_r};
        end else if (rd && addr_hit(wb_adr_i, ARO_STATUS_OFS)) begin
            dat_nxt = {30'h0000000, rdy_r};
        end else if (rd && addr_hit(wb_adr_i, ARO_MODE_OFS)) begin
            dat_nxt = {28'h0000000, pri_en_r, mode_r};
        end

        // new results only land while the flag is clear
        if (pri_conv_valid && !rdy_r[ARO_STA_PRI_RDY_BIT]) begin
            pri_res_nxt = pri_conv_data;
            rdy_nxt[ARO_STA_PRI_RDY_BIT] = 1'b1;
        end
        if (aux_conv_valid && !rdy_r[ARO_STA_AUX_RDY_BIT]) begin
            aux_res_nxt = aux_conv_data;
            rdy_nxt[ARO_STA_AUX_RDY_BIT] = 1'b1;
        end

        // mode register write
        if (wr && addr_hit(wb_adr_i, ARO_MODE_OFS) && wb_sel_i[0]) begin
            pri_en_nxt = wb_dat_i[ARO_MODE_PRI_EN_BIT];
            if (mode_legal(wb_dat_i[ARO_MODE_LSB +: ARO_MODE_W])) begin
                mode_nxt = aro_mode_t'(wb_dat_i[ARO_MODE_LSB +: ARO_MODE_W]);
            end
        end

        // coefficient: factory load, then calibration, then software
        if (factory_load_r) begin
            coef_nxt = factory_offset;
        end else if (cal_done && (mode_r == ARO_MODE_OFS_CAL)) begin
            coef_nxt = cal_offset;
            mode_nxt = ARO_MODE_IDLE;
        end else if (wr && addr_hit(wb_adr_i, ARO_PRI_OFFSET_OFS) && coef_wr_ok) begin
            if (wb_sel_i[0]) begin
                coef_nxt[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                coef_nxt[15:8] = wb_dat_i[15:8];
            end
        end
        // writes to result addresses fall through with no effect
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            dat_r <= ARO_DATA_ZERO;
            pri_res_r <= ARO_RESULT_RST;
            aux_res_r <= ARO_RESULT_RST;
            rdy_r <= 2'b00;
            coef_r <= ARO_COEF_RST;
            factory_load_r <= 1'b1;
            mode_r <= ARO_MODE_RST;
            pri_en_r <= ARO_PRI_EN_RST;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            pri_res_r <= pri_res_nxt;
            aux_res_r <= aux_res_nxt;
            rdy_r <= rdy_nxt;
            coef_r <= coef_nxt;
            factory_load_r <= factory_load_nxt;
            mode_r <= mode_nxt;
            pri_en_r <= pri_en_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign converter_mode = mode_r;
    assign pri_enable = pri_en_r;
    assign primary_offset_coefficient = coef_r;
    assign pri_ready = rdy_r[ARO_STA_PRI_RDY_BIT];
    assign aux_ready = rdy_r[ARO_STA_AUX_RDY_BIT];

endmodule : aro_regs

// ### src/aro_pkg.sv
// shared constants for the converter result and offset register block
// assumes a 32-bit classic wishbone bus with byte addresses

package aro_pkg;

    // ****************************************
    // bus and register map
    // ****************************************
    localparam int unsigned ARO_AW = 32;
    localparam int unsigned ARO_DW = 32;
    localparam int unsigned ARO_SW = 4;
    localparam logic [31:0] ARO_PRI_RESULT_OFS = 32'hFFFF051C;
    localparam logic [31:0] ARO_AUX_RESULT_OFS = 32'hFFFF0520;
    localparam logic [31:0] ARO_PRI_OFFSET_OFS = 32'hFFFF0524;
    localparam logic [31:0] ARO_STATUS_OFS = 32'hFFFF0540;
    localparam logic [31:0] ARO_MODE_OFS = 32'hFFFF0544;

    // ****************************************
    // field layouts and reset values
    // ****************************************
    localparam int unsigned ARO_RESULT_W = 24;
    localparam int unsigned ARO_COEF_W = 16;
    localparam logic [23:0] ARO_RESULT_RST = 24'h000000;
    localparam logic [15:0] ARO_COEF_RST = 16'h0000;
    localparam int unsigned ARO_STA_PRI_RDY_BIT = 0;
    localparam int unsigned ARO_STA_AUX_RDY_BIT = 1;
    localparam int unsigned ARO_MODE_LSB = 0;
    localparam int unsigned ARO_MODE_W = 3;
    localparam int unsigned ARO_MODE_PRI_EN_BIT = 3;
    localparam logic [31:0] ARO_DATA_ZERO = 32'h00000000;

    typedef enum logic [2:0] {
        ARO_MODE_OFF = 3'h0,
        ARO_MODE_IDLE = 3'h1,
        ARO_MODE_SINGLE = 3'h3,
        ARO_MODE_CONT = 3'h2,
        ARO_MODE_OFS_CAL = 3'h6
    } aro_mode_t;

    localparam aro_mode_t ARO_MODE_RST = ARO_MODE_OFF;
    localparam logic ARO_PRI_EN_RST = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned ARO_CLK_PERIOD_NS = 4;
    localparam int unsigned ARO_IDLE_SETTLE_NS = 23000;
    localparam int unsigned ARO_IDLE_SETTLE_CYCLES =
        (ARO_IDLE_SETTLE_NS + ARO_CLK_PERIOD_NS - 1) / ARO_CLK_PERIOD_NS;

endpackage : aro_pkg

// ### src/aro_idle_timer.sv
// idle qualification timer: flags when the converter has stayed idle long enough
// assumes idle_active is synchronous to ref_clk

`timescale 1ns/100ps

module aro_idle_timer #(
    parameter int unsigned SETTLE_CYCLES = 5750
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic idle_active,
    output logic idle_ok
);
    import aro_pkg::*;

    localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(SETTLE_CYCLES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic ok_r;
    logic ok_nxt;

    initial begin
        if (SETTLE_CYCLES < 1) begin
            $error("settle count must be at least one cycle");
        end
    end

    // ****************************************
    // settle counter
    // ****************************************
    always_comb begin
        cnt_nxt = cnt_r;
        if (!idle_active) begin
            cnt_nxt = '0;
        end else if (cnt_r < LIMIT) begin
            cnt_nxt = cnt_r + CW'(1);
        end
        ok_nxt = idle_active && (cnt_nxt == LIMIT);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            ok_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ok_r <= ok_nxt;
        end
    end

    assign idle_ok = ok_r;

endmodule : aro_idle_timer

// ### tb/aro_regs_props.sv
// checker for the result and offset register block
// assumes it is bound onto aro_regs, one clock domain
`timescale 1ns/100ps
module aro_regs_props
    import aro_pkg::*;
#(
    parameter int unsigned IDLE_SETTLE_CYCLES = 5750
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aro_pkg::ARO_AW-1:0] wb_adr_i,
    input wire logic [aro_pkg::ARO_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pri_conv_valid,
    input wire logic aux_conv_valid,
    input wire logic cal_done,
    input wire logic [aro_pkg::ARO_COEF_W-1:0] cal_offset,
    input wire logic [aro_pkg::ARO_COEF_W-1:0] factory_offset,
    input wire logic [aro_pkg::ARO_MODE_W-1:0] converter_mode,
    input wire logic [aro_pkg::ARO_COEF_W-1:0] primary_offset_coefficient,
    input wire logic pri_ready,
    input wire logic aux_ready
);
    // ****************************************
    // helpers
    // ****************************************
    logic up_r;
    logic up_nxt;
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire res = wb_adr_i == ARO_PRI_RESULT_OFS || wb_adr_i == ARO_AUX_RESULT_OFS;
    wire rd_pri = tk & ~wb_we_i & (wb_adr_i == ARO_PRI_RESULT_OFS);
    wire no_conv = ~pri_conv_valid & ~aux_conv_valid;
    wire cal = cal_done && converter_mode == ARO_MODE_OFS_CAL;
    always_comb up_nxt = 1'h1;
    // marks edges after the factory load edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) up_r <= 1'h0;
        else up_r <= up_nxt;
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_ack_single: assert property (tk |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
    a_result_upper: assert property (tk && !wb_we_i && res |=> wb_dat_o[31:24] == 8'h00)
        else $error("result upper bits set");
    a_read_clears: assert property (rd_pri && no_conv |=> !pri_ready && !aux_ready)
        else $error("flags not cleared");
    a_flag_holds: assert property (pri_ready && !rd_pri |=> pri_ready) else $error("flag lost");
    a_ro_write: assert property (tk && wb_we_i && res && no_conv |=> $stable({pri_ready, aux_ready}))
        else $error("result write moved flags");
    a_factory_load: assert property ($rose(up_r) |-> primary_offset_coefficient == $past(factory_offset))
        else $error("factory value not loaded");
    a_cal_load: assert property (up_r && cal |=> primary_offset_coefficient == $past(cal_offset))
        else $error("calibration not stored");
    a_coef_guard: assert property (up_r && converter_mode != ARO_MODE_IDLE && !cal
        |=> $stable(primary_offset_coefficient)) else $error("coefficient moved");
    c_read_flag: cover property (rd_pri && pri_ready);
    c_cal: cover property (cal);
    c_ro_write: cover property (tk && wb_we_i && res);
endmodule : aro_regs_props
bind aro_regs aro_regs_props #(.IDLE_SETTLE_CYCLES(IDLE_SETTLE_CYCLES)) u_props (
    .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pri_conv_valid(pri_conv_valid),
    .aux_conv_valid(aux_conv_valid), .cal_done(cal_done), .cal_offset(cal_offset), .factory_offset(factory_offset),
    .converter_mode(converter_mode), .primary_offset_coefficient(primary_offset_coefficient),
    .pri_ready(pri_ready), .aux_ready(aux_ready)
);

// ### tb/aro_regs_tb.sv
// self-checking bench for the result and offset register block
// assumes the checker file is compiled with it
`timescale 1ns/100ps
module aro_regs_tb;
    import aro_pkg::*;
    localparam int unsigned ST = 8;
    logic ref_clk = '0, nrst = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
    logic pri_conv_valid = '0, aux_conv_valid = '0, cal_done = '0, wb_ack_o, pri_enable, pri_ready, aux_ready;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o;
    logic [3:0] wb_sel_i = '0;
    logic [23:0] pri_conv_data = '0, aux_conv_data = '0, d[3];
    logic [15:0] cal_offset = '0, factory_offset = '0, fac, v, primary_offset_coefficient;
    logic [2:0] converter_mode;
    logic [34:0] e;
    logic [34:0] exp_q[$];
    int n_fail = 0;
    int num_checks = 0;
    aro_regs #(.IDLE_SETTLE_CYCLES(ST)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pri_conv_valid(pri_conv_valid), .pri_conv_data(pri_conv_data), .aux_conv_valid(aux_conv_valid),
        .aux_conv_data(aux_conv_data), .cal_done(cal_done), .cal_offset(cal_offset), .factory_offset(factory_offset),
        .converter_mode(converter_mode), .pri_enable(pri_enable),
        .primary_offset_coefficient(primary_offset_coefficient), .pri_ready(pri_ready), .aux_ready(aux_ready)
    );
    always #2 ref_clk = ~ref_clk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        num_checks++;
        if (g !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] x, input logic [3:0] s,
                       input logic [34:0] ex);
        int n;
        n = 0;
        exp_q.push_back(ex);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, x, s};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (n >= 20) begin
            n_fail++;
            wrap_up();
        end
    endtask : bus
    // read kind: 1 data only, 2 also mode port, 3 also ready flags, 4 also coefficient port
    task automatic rd(input logic [31:0] a, input logic [31:0] ex);
        logic [2:0] k;
        k = 3'h1;
        if (a == ARO_MODE_OFS) k = 3'h2;
        else if (a == ARO_STATUS_OFS) k = 3'h3;
        else if (a == ARO_PRI_OFFSET_OFS) k = 3'h4;
        bus(1'h0, a, 32'h0, 4'hF, {k, ex});
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] x, input logic [3:0] s);
        bus(1'h1, a, x, s, 35'h0);
    endtask : wr
    // one-cycle pulse on a converter or calibration input
    task automatic pulse(input int k, input logic [23:0] x);
        @(posedge ref_clk);
        {aux_conv_valid, pri_conv_valid, cal_done} <= 3'h1 << k;
        {pri_conv_data, aux_conv_data, cal_offset} <= {x, x, x[15:0]};
        @(posedge ref_clk);
        {aux_conv_valid, pri_conv_valid, cal_done} <= 3'h0;
    endtask : pulse
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'h1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[34:32] != 3'h0) chk("wb_dat_o", e[31:0], wb_dat_o);
            if (e[34:32] == 3'h2) chk("mode port", e[31:0], {28'h0, pri_enable, converter_mode});
            if (e[34:32] == 3'h3) chk("ready flags", e[31:0], {30'h0, aux_ready, pri_ready});
            if (e[34:32] == 3'h4) chk("coefficient", e[31:0], {16'h0, primary_offset_coefficient});
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fac = 16'($urandom(29));
        factory_offset <= fac;
        v = 16'($urandom());
        foreach (d[i]) d[i] = 24'($urandom());
        repeat (8) @(posedge ref_clk);
        nrst <= 1'h1;
        rd(ARO_PRI_RESULT_OFS, 32'h0);
        rd(ARO_AUX_RESULT_OFS, 32'h0);
        rd(ARO_PRI_OFFSET_OFS, {16'h0, fac});
        rd(32'hFFFF0600, 32'h0);
        $display("test reset values done");
        pulse(1, d[0]);
        pulse(1, d[1]);
        pulse(2, d[2]);
        pulse(2, d[0]);
        wr(ARO_PRI_RESULT_OFS, 32'hFFFFFFFF, 4'hF);
        rd(ARO_STATUS_OFS, 32'h3);
        rd(ARO_AUX_RESULT_OFS, {8'h0, d[2]});
        rd(ARO_PRI_RESULT_OFS, {8'h0, d[0]});
        rd(ARO_STATUS_OFS, 32'h0);
        pulse(2, d[1]);
        rd(ARO_AUX_RESULT_OFS, {8'h0, d[1]});
        $display("test conversion results done");
        wr(ARO_MODE_OFS, 32'h1, 4'h1);
        repeat (ST + 2) @(posedge ref_clk);
        wr(ARO_PRI_OFFSET_OFS, {16'h0, v}, 4'h3);
        wr(ARO_MODE_OFS, 32'hA, 4'h1);
        repeat (ST + 2) @(posedge ref_clk);
        wr(ARO_PRI_OFFSET_OFS, {16'h0, v}, 4'h3);
        wr(ARO_MODE_OFS, 32'h9, 4'h1);
        wr(ARO_PRI_OFFSET_OFS, {16'h0, v}, 4'h3);
        rd(ARO_PRI_OFFSET_OFS, {16'h0, fac});
        repeat (ST + 2) @(posedge ref_clk);
        wr(ARO_PRI_OFFSET_OFS, {16'h0, v}, 4'h2);
        rd(ARO_PRI_OFFSET_OFS, {16'h0, v[15:8], fac[7:0]});
        $display("test coefficient writes done");
        wr(ARO_MODE_OFS, 32'hA, 4'h1);
        pulse(0, {8'h0, ~v});
        rd(ARO_PRI_OFFSET_OFS, {16'h0, v[15:8], fac[7:0]});
        wr(ARO_MODE_OFS, 32'hE, 4'h1);
        pulse(0, {8'h0, ~v});
        rd(ARO_PRI_OFFSET_OFS, {16'h0, ~v});
        rd(ARO_MODE_OFS, 32'h9);
        $display("test calibration done");
        wr(ARO_MODE_OFS, 32'hB, 4'h1);
        rd(ARO_MODE_OFS, 32'hB);
        wr(ARO_MODE_OFS, 32'h7, 4'h1);
        rd(ARO_MODE_OFS, 32'h3);
        $display("test mode writes done");
        fac = 16'($urandom());
        @(posedge ref_clk);
        {nrst, factory_offset} <= {1'h0, fac};
        repeat (8) @(posedge ref_clk);
        nrst <= 1'h1;
        rd(ARO_PRI_OFFSET_OFS, {16'h0, fac});
        rd(ARO_AUX_RESULT_OFS, 32'h0);
        rd(ARO_STATUS_OFS, 32'h0);
        rd(ARO_MODE_OFS, 32'h0);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : aro_regs_tb
